// file: rtl/ccd_top.sv
// clock divider path: source select, prescaler, three channel dividers, AXI4-Lite registers
// assumes clock sources are slow enough to be sampled at clk; AXI master on clk
// Functional notes
// - total division is prescaler times channel ratio
// - prescaler ratios 2 to 6, three-bit field
// - three channel dividers, each drives an output pair
// - bypass passes input through, idles divider
// - four-bit low and high counts, minus one
// - channels 1 and 2 offset by three, six
// - unbypassed divider divides by N+M+2
// - counts use divider input clock cycles
// - duty fix on after reset, disable per channel
// - uncorrected output high N+1, low M+1
// - bypass after odd prescaler: uncorrected or fifty
// - corrected bypass follows odd prescaler formulas
// - no prescaler: bypass keeps input duty
// - direct route keeps source duty cycle
// - two-bit source select, code three forbidden
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "ccd_defs.svh"

module ccd_top
	import ccd_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic extClkIn,
	input wire logic oscClkIn,
	output logic outputPair0A,
	output logic outputPair0B,
	output logic outputPair1A,
	output logic outputPair1B,
	output logic outputPair2A,
	output logic outputPair2B,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	// maps a byte address to a register slot
	function automatic logic [3:0] regSlot(input logic [11:0] addr);
		logic [9:0] idx;
		logic [9:0] rel;
		idx = addr[11:2];
		rel = idx - `CCD_IDX_CH0_COUNTS;
		if (addr[1:0] != 2'h0) begin
			regSlot = `CCD_SLOT_NONE;
		end else if (idx >= `CCD_IDX_CH0_COUNTS && idx <= `CCD_IDX_CH2_DUTY) begin
			regSlot = rel[3:0];
		end else if (idx == `CCD_IDX_PRESC) begin
			regSlot = `CCD_SLOT_PRESC;
		end else if (idx == `CCD_IDX_SRC_SEL) begin
			regSlot = `CCD_SLOT_SRC;
		end else begin
			regSlot = `CCD_SLOT_NONE;
		end
	endfunction

	// maps the ratio field to a usable ratio
	function automatic logic [2:0] prescRatio(input logic [2:0] field);
		if (field < `CCD_RATIO_MIN || field > `CCD_RATIO_MAX) begin
			prescRatio = `CCD_RATIO_MIN;
		end else begin
			prescRatio = field;
		end
	endfunction

	// ---- register file ----
	logic [7:0] regs_q [`CCD_NUM_REGS];

	// ---- write channel ----
	logic awHeld_q;
	logic [11:0] awAddr_q;
	logic wHeld_q;
	logic [31:0] wData_q;
	logic [3:0] wStrb_q;
	logic bValid_q;
	logic [1:0] bResp_q;

	wire awTake = s_axi_awvalid & s_axi_awready;
	wire wTake = s_axi_wvalid & s_axi_wready;
	wire doWrite = awHeld_q & wHeld_q & ~bValid_q;
	wire [3:0] wrSlot = regSlot(awAddr_q);
	wire wrHit = (wrSlot != `CCD_SLOT_NONE);
	wire wrLane = wStrb_q[0];

	assign s_axi_awready = ~awHeld_q & ~bValid_q;
	assign s_axi_wready = ~wHeld_q & ~bValid_q;
	assign s_axi_bvalid = bValid_q;
	assign s_axi_bresp = bResp_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			awHeld_q <= 1'b0;
			awAddr_q <= 12'h000;
		end else if (awTake) begin
			awHeld_q <= 1'b1;
			awAddr_q <= s_axi_awaddr;
		end else if (doWrite) begin
			awHeld_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wHeld_q <= 1'b0;
			wData_q <= 32'h00000000;
			wStrb_q <= 4'h0;
		end else if (wTake) begin
			wHeld_q <= 1'b1;
			wData_q <= s_axi_wdata;
			wStrb_q <= s_axi_wstrb;
		end else if (doWrite) begin
			wHeld_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bValid_q <= 1'b0;
			bResp_q <= `CCD_RESP_OKAY;
		end else if (doWrite) begin
			bValid_q <= 1'b1;
			bResp_q <= wrHit ? `CCD_RESP_OKAY : `CCD_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bValid_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < 9; i++) begin
				if (i % 3 == 0) begin
					regs_q[i] <= `CCD_RST_COUNTS;
				end else if (i % 3 == 1) begin
					regs_q[i] <= `CCD_RST_BYPASS;
				end else begin
					regs_q[i] <= `CCD_RST_DUTY;
				end
			end
			regs_q[`CCD_SLOT_PRESC] <= `CCD_RST_PRESC;
			regs_q[`CCD_SLOT_SRC] <= `CCD_RST_SRC;
		end else if (doWrite && wrHit && wrLane) begin
			regs_q[wrSlot] <= wData_q[7:0];
		end
	end

	// ---- read channel ----
	logic rValid_q;
	logic [31:0] rData_q;
	logic [1:0] rResp_q;

	wire arTake = s_axi_arvalid & s_axi_arready;
	wire [3:0] rdSlot = regSlot(s_axi_araddr);
	wire rdHit = (rdSlot != `CCD_SLOT_NONE);
	wire [7:0] rdByte = rdHit ? regs_q[rdSlot] : 8'h00;

	assign s_axi_arready = ~rValid_q;
	assign s_axi_rvalid = rValid_q;
	assign s_axi_rdata = rData_q;
	assign s_axi_rresp = rResp_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rValid_q <= 1'b0;
			rData_q <= 32'h00000000;
			rResp_q <= `CCD_RESP_OKAY;
		end else if (arTake) begin
			rValid_q <= 1'b1;
			rData_q <= {24'h000000, rdByte};
			rResp_q <= rdHit ? `CCD_RESP_OKAY : `CCD_RESP_SLVERR;
		end else if (s_axi_rready) begin
			rValid_q <= 1'b0;
		end
	end

	// ---- configuration decode ----
	wire [1:0] srcSel = regs_q[`CCD_SLOT_SRC][`CCD_SRC_MSB:0];
	wire pathEnable = (srcSel != `CCD_SRC_FORBIDDEN);
	wire usePresc = (srcSel == `CCD_SRC_EXT_PRESC) | (srcSel == `CCD_SRC_OSC_PRESC);
	wire useOsc = (srcSel == `CCD_SRC_OSC_PRESC);
	wire [2:0] ratioSel = prescRatio(regs_q[`CCD_SLOT_PRESC][`CCD_PRESC_MSB:0]);

	ccd_chan_cfg_t chanCfg [3];

	for (genvar c = 0; c < 3; c++) begin : g_cfg
		localparam int Base = 3 * c;
		assign chanCfg[c].counts.lowCnt = regs_q[Base][`CCD_LOW_MSB:`CCD_LOW_LSB];
		assign chanCfg[c].counts.highCnt = regs_q[Base][`CCD_HIGH_MSB:`CCD_HIGH_LSB];
		assign chanCfg[c].bypass = regs_q[Base + 1][`CCD_BYPASS_BIT];
		assign chanCfg[c].dutyFixDisable = regs_q[Base + 2][`CCD_DUTY_OFF_BIT];
		// direct route only exists when the prescaler input is selected
		assign chanCfg[c].direct = regs_q[Base + 2][`CCD_DIRECT_BIT] & usePresc;
	end

	// ---- source sampling ----
	logic [1:0] srcMeta_q;
	logic [1:0] srcSync_q;
	logic srcLast_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			srcMeta_q <= 2'h0;
			srcSync_q <= 2'h0;
		end else begin
			srcMeta_q <= {oscClkIn, extClkIn};
			srcSync_q <= srcMeta_q;
		end
	end

	wire srcLevel = useOsc ? srcSync_q[1] : srcSync_q[0];

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			srcLast_q <= 1'b0;
		end else begin
			srcLast_q <= srcLevel;
		end
	end

	// a change of source is not an edge of the new source
	logic srcPick_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			srcPick_q <= 1'b0;
		end else begin
			srcPick_q <= useOsc;
		end
	end

	wire srcSwitch = (srcPick_q != useOsc);
	wire srcRise = srcLevel & ~srcLast_q & ~srcSwitch;
	wire srcFall = ~srcLevel & srcLast_q & ~srcSwitch;

	// ---- prescaler ----
	logic [2:0] presCnt_q;
	logic [2:0] presRatio_q;
	logic presBase_q;
	logic presExt_q;
	logic presRise_q;
	logic presFall_q;

	wire presWrap = (presCnt_q == presRatio_q - 3'h1);
	wire [2:0] presCntNext = presWrap ? 3'h0 : presCnt_q + 3'h1;
	wire [2:0] presRatioNext = presWrap ? ratioSel : presRatio_q;
	wire [2:0] presHalf = {1'b0, presRatioNext[2:1]};
	wire presOdd = presRatio_q[0];
	// half-cycle point: source rise for even ratios, following fall for odd ones
	wire presFallEven = srcRise & (presCntNext == presHalf);
	wire presFallOdd = srcFall & presExt_q & ~presBase_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			presCnt_q <= 3'h0;
			presRatio_q <= `CCD_RATIO_MIN;
			presBase_q <= 1'b0;
			presRise_q <= 1'b0;
			presFall_q <= 1'b0;
		end else if (!usePresc) begin
			presCnt_q <= 3'h0;
			presRatio_q <= ratioSel;
			presBase_q <= 1'b0;
			presRise_q <= 1'b0;
			presFall_q <= 1'b0;
		end else begin
			presRise_q <= srcRise & (presCntNext == 3'h0);
			presFall_q <= presOdd ? presFallOdd : presFallEven;
			if (srcRise) begin
				presCnt_q <= presCntNext;
				presRatio_q <= presRatioNext;
				presBase_q <= (presCntNext < presHalf);
			end
		end
	end

	// stretched copy for odd ratios, released on the source falling edge
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			presExt_q <= 1'b0;
		end else if (!usePresc) begin
			presExt_q <= 1'b0;
		end else if (srcRise && presCntNext == 3'h0) begin
			presExt_q <= 1'b1;
		end else if (srcFall && !presBase_q) begin
			presExt_q <= 1'b0;
		end
	end

	// ---- divider input selection ----
	ccd_div_in_t divIn;

	assign divIn.rise = usePresc ? presRise_q : srcRise;
	assign divIn.fall = usePresc ? presFall_q : srcFall;
	assign divIn.level = usePresc ? presBase_q : srcLevel;
	assign divIn.levelFixed = usePresc ? (presOdd ? presExt_q : presBase_q) : srcLevel;

	// ---- channels ----
	logic [2:0] chanOut;

	for (genvar c = 0; c < 3; c++) begin : g_chan
		ccd_chan_div u_chan (
			.clk(clk),
			.rst(rst),
			.enable(pathEnable),
			.divIn(divIn),
			.srcLevel(srcLevel),
			.cfg(chanCfg[c]),
			.chanOut(chanOut[c])
		);
	end

	assign outputPair0A = chanOut[0];
	assign outputPair0B = chanOut[0];
	assign outputPair1A = chanOut[1];
	assign outputPair1B = chanOut[1];
	assign outputPair2A = chanOut[2];
	assign outputPair2B = chanOut[2];

endmodule
`default_nettype wire

// file: rtl/ccd_defs.svh
// register indices, field positions, reset values and codes of the clock divider path
// assumes inclusion by bare name from the design files
`ifndef CCD_DEFS_SVH
`define CCD_DEFS_SVH

`define CCD_IDX_CH0_COUNTS 10'h190
`define CCD_IDX_CH0_BYPASS 10'h191
`define CCD_IDX_CH0_DUTY 10'h192
`define CCD_IDX_CH1_COUNTS 10'h193
`define CCD_IDX_CH1_BYPASS 10'h194
`define CCD_IDX_CH1_DUTY 10'h195
`define CCD_IDX_CH2_COUNTS 10'h196
`define CCD_IDX_CH2_BYPASS 10'h197
`define CCD_IDX_CH2_DUTY 10'h198
`define CCD_IDX_PRESC 10'h1e0
`define CCD_IDX_SRC_SEL 10'h1e1
`define CCD_CH_STRIDE 4'h3

`define CCD_NUM_REGS 11
`define CCD_SLOT_PRESC 4'h9
`define CCD_SLOT_SRC 4'ha
`define CCD_SLOT_NONE 4'hf

`define CCD_LOW_MSB 7
`define CCD_LOW_LSB 4
`define CCD_HIGH_MSB 3
`define CCD_HIGH_LSB 0
`define CCD_BYPASS_BIT 7
`define CCD_DUTY_OFF_BIT 0
`define CCD_DIRECT_BIT 1
`define CCD_PRESC_MSB 2
`define CCD_SRC_MSB 1

`define CCD_RST_COUNTS 8'h00
`define CCD_RST_BYPASS 8'h00
`define CCD_RST_DUTY 8'h00
`define CCD_RST_PRESC 8'h02
`define CCD_RST_SRC 8'h00

`define CCD_RATIO_MIN 3'h2
`define CCD_RATIO_MAX 3'h6

`define CCD_SRC_EXT_PRESC 2'h0
`define CCD_SRC_EXT_DIRECT 2'h1
`define CCD_SRC_OSC_PRESC 2'h2
`define CCD_SRC_FORBIDDEN 2'h3

`define CCD_RESP_OKAY 2'h0
`define CCD_RESP_SLVERR 2'h2

`endif

// file: rtl/ccd_pkg.sv
// types shared by the clock divider path
// assumes ccd_defs.svh for numeric constants
package ccd_pkg;

	typedef struct packed {
		logic [3:0] lowCnt;
		logic [3:0] highCnt;
	} ccd_counts_t;

	typedef struct packed {
		ccd_counts_t counts;
		logic bypass;
		logic dutyFixDisable;
		logic direct;
	} ccd_chan_cfg_t;

	typedef struct packed {
		logic rise;
		logic fall;
		logic level;
		logic levelFixed;
	} ccd_div_in_t;

	typedef enum logic {
		CCD_PH_HIGH,
		CCD_PH_LOW
	} ccd_phase_t;

endpackage

// file: rtl/ccd_chan_div.sv
// one channel divider: high/low counting, bypass, direct route, duty fix
// assumes divider input events already synchronised to clk
`timescale 1ns/10ps
`default_nettype none
`include "ccd_defs.svh"

module ccd_chan_div
	import ccd_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic enable,
	input wire ccd_div_in_t divIn,
	input wire logic srcLevel,
	input wire ccd_chan_cfg_t cfg,
	output logic chanOut
);

	ccd_phase_t phase_q, phase_d;
	logic [3:0] cnt_q, cnt_d;
	ccd_counts_t shadow_q, shadow_d;
	logic extend_q, extend_d;
	logic out_q, out_d;

	// bypass holds the counter idle
	wire running = enable & ~cfg.bypass & ~cfg.direct;
	wire dutyFix = ~cfg.dutyFixDisable;
	wire [3:0] phaseLimit = (phase_q == CCD_PH_HIGH) ? shadow_q.highCnt : shadow_q.lowCnt;
	wire phaseEnd = divIn.rise & (cnt_q == phaseLimit);
	wire oddSplit = ({1'b0, shadow_q.lowCnt} == ({1'b0, shadow_q.highCnt} + 5'h01));

	always_comb begin
		phase_d = phase_q;
		cnt_d = cnt_q;
		shadow_d = shadow_q;
		extend_d = extend_q;
		if (!running) begin
			phase_d = CCD_PH_HIGH;
			cnt_d = 4'h0;
			shadow_d = cfg.counts;
			extend_d = 1'b0;
		end else if (phaseEnd) begin
			cnt_d = 4'h0;
			if (phase_q == CCD_PH_HIGH) begin
				phase_d = CCD_PH_LOW;
				extend_d = dutyFix & oddSplit;
			end else begin
				phase_d = CCD_PH_HIGH;
				shadow_d = cfg.counts;
			end
		end else begin
			if (divIn.rise) begin
				cnt_d = cnt_q + 4'h1;
			end
			if (divIn.fall) begin
				extend_d = 1'b0;
			end
		end
	end

	always_comb begin
		if (!enable) begin
			out_d = 1'b0;
		end else if (cfg.direct) begin
			out_d = srcLevel;
		end else if (cfg.bypass) begin
			out_d = dutyFix ? divIn.levelFixed : divIn.level;
		end else begin
			out_d = (phase_d == CCD_PH_HIGH) | extend_d;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			phase_q <= CCD_PH_HIGH;
			cnt_q <= 4'h0;
			shadow_q <= '0;
			extend_q <= 1'b0;
			out_q <= 1'b0;
		end else begin
			phase_q <= phase_d;
			cnt_q <= cnt_d;
			shadow_q <= shadow_d;
			extend_q <= extend_d;
			out_q <= out_d;
		end
	end

	assign chanOut = out_q;

endmodule
`default_nettype wire

// file: test/ccd_chk.sv
// checker: axi handshakes and output pairs of ccd_top
// assumes bind onto ccd_top, one clock domain
`timescale 1ns/10ps
`default_nettype none
`include "ccd_defs.svh"
module ccd_chk (
	input wire logic clk,
	input wire logic rst,
	input wire logic outputPair0A,
	input wire logic outputPair0B,
	input wire logic outputPair1A,
	input wire logic outputPair1B,
	input wire logic outputPair2A,
	input wire logic outputPair2B,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	AST_PAIR0: assert property (outputPair0A == outputPair0B)
		else $error("pair 0 differs");
	AST_PAIR12: assert property (outputPair1A == outputPair1B && outputPair2A == outputPair2B)
		else $error("pair 1 or 2 differs");
	AST_RLAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	AST_RHOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	AST_RUP: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0 && !s_axi_arready)
		else $error("read upper bits or arready");
	AST_BLAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|=> (!s_axi_awready && !s_axi_wready) ##1 s_axi_bvalid)
		else $error("write answer late");
	AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	AST_MISAL: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[1:0] != 2'h0
		|=> s_axi_rresp == `CCD_RESP_SLVERR)
		else $error("misaligned read not refused");
	AST_MAP: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h640
		|=> s_axi_rresp == `CCD_RESP_OKAY)
		else $error("mapped read refused");
endmodule
bind ccd_top ccd_chk u_chk (.clk, .rst, .outputPair0A, .outputPair0B, .outputPair1A, .outputPair1B,
	.outputPair2A, .outputPair2B, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// file: test/ccd_sink.sv
// clock consumer model: measures high and low lengths in clk cycles
// assumes output is a level sampled on clk
`timescale 1ns/10ps
`default_nettype none
module ccd_sink (
	input wire logic clk,
	input wire logic rst,
	input wire logic sig,
	output logic [15:0] hiLen,
	output logic [15:0] loLen,
	output logic [7:0] rises
);
	logic [15:0] cnt;
	logic prev;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt <= 16'h1;
			prev <= 1'b0;
			hiLen <= 16'h0;
			loLen <= 16'h0;
			rises <= 8'h0;
		end else if (sig != prev) begin
			prev <= sig;
			cnt <= 16'h1;
			if (prev) hiLen <= cnt;
			else loLen <= cnt;
			if (sig) rises <= rises + 8'h1;
		end else cnt <= cnt + 16'h1;
	end
endmodule
`default_nettype wire

// file: test/clock_channel_divider_path_bench.sv
// bench: registers over axi, output periods measured by sinks
// assumes sources of 8 clk period, made on clk
`timescale 1ns/10ps
`default_nettype none
`define CMP(nm, e, s) begin checked++; if ((s) !== (e)) begin numErrors++; \
	$display("[FAIL] %s exp %h got %h", nm, e, s); end end
module clock_channel_divider_path_bench;
	logic clk = 1'b0, rst = 1'b1, extClk = 1'b0, oscClk = 1'b1;
	logic [2:0] srcCnt = 3'h0;
	logic [11:0] awaddr = 12'h0, araddr = 12'h0;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0] wstrb = 4'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [5:0] outs;
	logic [15:0] hiL [3], loL [3];
	logic [7:0] rises [3];
	int numErrors = 0, checked = 0;
	always #12.5 clk = ~clk;
	always @(posedge clk) begin
		srcCnt <= srcCnt + 3'h1;
		extClk <= srcCnt[2];
		oscClk <= ~srcCnt[2];
	end
	ccd_top u_dut (.clk(clk), .rst(rst), .extClkIn(extClk), .oscClkIn(oscClk),
		.outputPair0A(outs[0]), .outputPair0B(outs[1]), .outputPair1A(outs[2]),
		.outputPair1B(outs[3]), .outputPair2A(outs[4]), .outputPair2B(outs[5]),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	for (genvar i = 0; i < 3; i++) begin : g_sink
		ccd_sink u_sink (.clk(clk), .rst(rst), .sig(outs[2*i]), .hiLen(hiL[i]), .loLen(loL[i]),
			.rises(rises[i]));
	end
	task automatic finalReport;
		if (numErrors == 0 && checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic tmo(input int n, input int lim);
		if (n >= lim) begin
			numErrors++;
			$display("[FAIL] wait exp %h got %h", lim, n);
			finalReport();
		end
	endtask
	task automatic axw(input logic [11:0] a, input logic [7:0] d);
		int n;
		logic aw, w;
		@(posedge clk);
		awaddr <= a;
		wdata <= {24'h0, d};
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		aw = 1'b1;
		w = 1'b1;
		n = 0;
		while (aw || w) begin
			@(negedge clk);
			if (aw && awready) aw = 1'b0;
			if (w && wready) w = 1'b0;
			@(posedge clk);
			awvalid <= aw;
			wvalid <= w;
			n++;
			tmo(n, 50);
		end
		do begin @(negedge clk); n++; tmo(n, 100); end while (!bvalid);
		`CMP("bresp", 2'h0, bresp)
		@(posedge clk);
		bready <= 1'b1;
		@(posedge clk);
		bready <= 1'b0;
	endtask
	task automatic axr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
		int n;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		n = 0;
		do begin @(negedge clk); n++; tmo(n, 50); end while (!arready);
		@(posedge clk);
		arvalid <= 1'b0;
		do begin @(negedge clk); n++; tmo(n, 100); end while (!rvalid);
		`CMP("rdata", {24'h0, d}, rdata)
		`CMP("rresp", r, rresp)
		@(posedge clk);
		rready <= 1'b1;
		@(posedge clk);
		rready <= 1'b0;
	endtask
	task automatic meas(input int ch, input logic [15:0] hi, input logic [15:0] lo);
		int n;
		logic [7:0] r0;
		r0 = rises[ch];
		n = 0;
		do begin @(negedge clk); n++; tmo(n, 2000); end while (8'(rises[ch] - r0) < 8'h4);
		`CMP("high", hi, hiL[ch])
		`CMP("low", lo, loL[ch])
	endtask
	task automatic tRegs;
		axr(12'h640, 8'h00, 2'h0);
		axr(12'h648, 8'h00, 2'h0);
		axr(12'h660, 8'h00, 2'h0);
		axr(12'h780, 8'h02, 2'h0);
		axr(12'h7fc, 8'h00, 2'h2);
		axr(12'h641, 8'h00, 2'h2);
		axw(12'h658, 8'h5a);
		axr(12'h658, 8'h5a, 2'h0);
		axw(12'h658, 8'h00);
	endtask
	task automatic tDiv;
		axw(12'h784, 8'h01);
		axw(12'h640, 8'h21);
		axw(12'h648, 8'h01);
		meas(0, 16'd16, 16'd24);
		axw(12'h640, 8'h22);
		axw(12'h648, 8'h00);
		meas(0, 16'd24, 16'd24);
	endtask
	task automatic tOddFix;
		axw(12'h64c, 8'h10);
		meas(1, 16'd12, 16'd12);
		axw(12'h654, 8'h01);
		meas(1, 16'd8, 16'd16);
		axw(12'h654, 8'h00);
	endtask
	task automatic tPresc;
		axw(12'h784, 8'h00);
		axw(12'h64c, 8'h00);
		for (int r = 2; r <= 6; r++) begin
			axw(12'h780, 8'(r));
			meas(1, 16'(8 * r), 16'(8 * r));
		end
		axw(12'h780, 8'h03);
		axw(12'h64c, 8'h10);
		meas(1, 16'd36, 16'd36);
	endtask
	task automatic tBypass;
		axw(12'h780, 8'h03);
		axw(12'h65c, 8'h80);
		axw(12'h660, 8'h01);
		meas(2, 16'd8, 16'd16);
		axw(12'h660, 8'h00);
		meas(2, 16'd12, 16'd12);
		axw(12'h780, 8'h05);
		meas(2, 16'd20, 16'd20);
	endtask
	task automatic tDirect;
		axw(12'h648, 8'h02);
		meas(0, 16'd4, 16'd4);
		axw(12'h784, 8'h02);
		meas(0, 16'd4, 16'd4);
		axw(12'h784, 8'h01);
		meas(0, 16'd24, 16'd24);
	endtask
	task automatic tForbid;
		logic [7:0] r0;
		axw(12'h784, 8'h03);
		repeat (4) @(negedge clk);
		r0 = rises[0];
		repeat (100) @(negedge clk);
		`CMP("quiet", 6'h00, outs)
		`CMP("rises", r0, rises[0])
	endtask
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		tRegs();
		tDiv();
		tOddFix();
		tPresc();
		tBypass();
		tDirect();
		tForbid();
		finalReport();
	end
endmodule
`default_nettype wire
